// file: rtl/inband_mgmt_status.v
// status and control registers of the in-band management engine
//
// Notes on behaviour
// - good-frame flag, bit 31, set once a valid management frame is received.
// - response-sent flag, bit 30, set when the response frame has gone out.
// - execution-done flag, bit 29, set when all commands of a frame finished.
// - new frame with matching tag clears bits 30, 29 and all error flags.
// - bit 14 flags destination mismatch, only while address checking is enabled.
// - bit 13 flags an access format field other than 0x9800.
// - bit 12 flags access codes other than 0x0001 and 0x0002.
// - bit 11 flags an unrecognised command code in the frame.
// - bit 10 flags frames above 320 bytes, zero pad and check sequence counted.
// - an oversize frame gets no response frame.
// - bits 6:0 give the position of the unrecognised command code.
// - with control bit 30 set, frames with a foreign destination are discarded.
// - writing one to control bit 29 restarts the engine; the bit self-clears.
`timescale 1ns/1ps
`include "inband_mgmt_defs.vh"

module inband_mgmt_status (
	input  wire        clk,
	input  wire        nrst,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [15:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        frame_start,
	input  wire        tag_match,
	input  wire        byte_valid,
	input  wire        hdr_valid,
	input  wire [47:0] dest_addr,
	input  wire [15:0] access_format,
	input  wire [15:0] access_code,
	input  wire        cmd_valid,
	input  wire [7:0]  cmd_code,
	input  wire        frame_end,
	input  wire        exec_done,
	input  wire        resp_sent,
	output reg         frame_discard,
	output reg         resp_block,
	output reg         mgmt_reset,
	output reg         irq
);

	// ****************************************************************
	// frame states
	// ****************************************************************
	localparam [1:0] S_IDLE = 2'b00;
	localparam [1:0] S_HDR  = 2'b01;
	localparam [1:0] S_BODY = 2'b10;
	localparam [1:0] S_DROP = 2'b11;

	// ****************************************************************
	// functions
	// ****************************************************************
	function hit;
		input [15:0] adr;
		input [15:0] off;
		begin
			hit = (adr[15:2] == off[15:2]);
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] wr;
		input [3:0]  sel;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i]) begin
					merge[i*8 +: 8] = wr[i*8 +: 8];
				end
			end
		end
	endfunction

	function cmd_known;
		input [7:0] code;
		begin
			cmd_known = (code == `CMD_CODE_0) || (code == `CMD_CODE_1) ||
				(code == `CMD_CODE_2) || (code == `CMD_CODE_3);
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	reg [1:0]             state;
	reg [1:0]             next_state;
	reg [31:0]            status;
	reg [31:0]            next_status;
	reg                   check_en;
	reg [47:0]            own_addr;
	reg [`EV_WIDTH-1:0]   int_status;
	reg [`EV_WIDTH-1:0]   next_int;
	reg [`EV_WIDTH-1:0]   int_mask;
	reg [6:0]             cmd_pos;
	reg                   frame_bad;
	reg                   next_bad;
	reg                   next_discard;
	reg [`EV_WIDTH-1:0]   events;

	wire                  mac_err;
	wire                  fmt_err;
	wire                  code_err;
	wire                  oversize;
	wire                  bus_req;
	wire                  wr_req;
	wire                  tag_clear;
	wire                  cmd_bad;
	wire                  hdr_take;
	wire [31:0]           ctrl_rd;
	wire [`EV_WIDTH-1:0]  w1c;
	wire [31:0]           own_hi_wr;

	// ****************************************************************
	// submodules
	// ****************************************************************
	hdr_check u_hdr (
		.check_en      (check_en),
		.dest_addr     (dest_addr),
		.own_addr      (own_addr),
		.access_format (access_format),
		.access_code   (access_code),
		.mac_err       (mac_err),
		.fmt_err       (fmt_err),
		.code_err      (code_err)
	);

	frame_len u_len (
		.clk        (clk),
		.nrst       (nrst),
		.clr        (frame_start | mgmt_reset),
		.byte_valid (byte_valid),
		.oversize   (oversize)
	);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_req    = bus_req && wb_we_i;
	assign tag_clear = frame_start && tag_match;
	assign hdr_take  = hdr_valid && (state == S_HDR);
	assign cmd_bad   = cmd_valid && (state == S_BODY) && !cmd_known(cmd_code);
	assign ctrl_rd   = {1'b0, check_en, mgmt_reset, 29'h0000_0000};
	assign w1c       = (wr_req && hit(wb_adr_i, `OFF_INT_STATUS) && wb_sel_i[0]) ?
		wb_dat_i[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};
	assign own_hi_wr = merge({16'h0000, own_addr[47:32]}, wb_dat_i, wb_sel_i);

	// ****************************************************************
	// frame sequence
	// ****************************************************************
	always @* begin
		next_state   = state;
		next_discard = 1'b0;
		case (state)
		S_IDLE: begin
			next_state = S_IDLE;
		end
		S_HDR: begin
			if (hdr_valid) begin
				if (mac_err) begin
					next_state   = S_DROP;
					next_discard = 1'b1;
				end else begin
					next_state = S_BODY;
				end
			end
		end
		S_BODY: begin
			if (frame_end) begin
				next_state = S_IDLE;
			end
		end
		S_DROP: begin
			if (frame_end) begin
				next_state = S_IDLE;
			end
		end
		default: begin
			next_state = S_IDLE;
		end
		endcase
		// a fresh start always wins over the frame still in flight
		if (frame_start) begin
			next_state   = S_HDR;
			next_discard = 1'b0;
		end
	end

	// ****************************************************************
	// operation status update, set wins over clear
	// ****************************************************************
	always @* begin
		next_status = status;
		next_bad    = frame_bad;
		events      = {`EV_WIDTH{1'b0}};
		if (frame_start) begin
			next_bad = 1'b0;
		end
		if (tag_clear) begin
			next_status[`ST_RESP_BIT] = 1'b0;
			next_status[`ST_EXEC_BIT] = 1'b0;
			next_status[`ST_MAC_BIT:`ST_SIZE_BIT] = 5'h00;
			next_status[`ST_LOC_MSB:`ST_LOC_LSB] = 7'h00;
		end
		if (hdr_take) begin
			if (mac_err) begin
				next_status[`ST_MAC_BIT] = 1'b1;
			end
			if (fmt_err) begin
				next_status[`ST_FMT_BIT] = 1'b1;
			end
			if (code_err) begin
				next_status[`ST_CODE_BIT] = 1'b1;
			end
			if (mac_err || fmt_err || code_err) begin
				next_bad   = 1'b1;
				events[`EV_ERR] = 1'b1;
			end
		end
		// only the first bad command of a frame is located
		if (cmd_bad && !next_status[`ST_CMD_BIT]) begin
			next_status[`ST_CMD_BIT] = 1'b1;
			next_status[`ST_LOC_MSB:`ST_LOC_LSB] = cmd_pos;
			next_bad   = 1'b1;
			events[`EV_ERR] = 1'b1;
		end
		if (oversize && state != S_IDLE && !next_status[`ST_SIZE_BIT]) begin
			next_status[`ST_SIZE_BIT] = 1'b1;
			next_bad   = 1'b1;
			events[`EV_ERR] = 1'b1;
		end
		if (frame_end && state == S_BODY && !next_bad && !oversize) begin
			next_status[`ST_GOOD_BIT] = 1'b1;
			events[`EV_GOOD] = 1'b1;
		end
		if (exec_done) begin
			next_status[`ST_EXEC_BIT] = 1'b1;
			events[`EV_EXEC] = 1'b1;
		end
		if (resp_sent) begin
			next_status[`ST_RESP_BIT] = 1'b1;
			events[`EV_RESP] = 1'b1;
		end
		next_status[`ST_RSVD_HI_MSB:`ST_RSVD_HI_LSB] =
			{(`ST_RSVD_HI_MSB - `ST_RSVD_HI_LSB + 1){1'b0}};
		next_status[`ST_RSVD_LO_MSB:`ST_RSVD_LO_LSB] =
			{(`ST_RSVD_LO_MSB - `ST_RSVD_LO_LSB + 1){1'b0}};
		next_int = (int_status & ~w1c) | events;
	end

	// ****************************************************************
	// frame and status registers
	// ****************************************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state         <= S_IDLE;
			status        <= `ST_RESET;
			frame_bad     <= 1'b0;
			cmd_pos       <= 7'h00;
			frame_discard <= 1'b0;
			resp_block    <= 1'b0;
		end else if (mgmt_reset) begin
			state         <= S_IDLE;
			status        <= `ST_RESET;
			frame_bad     <= 1'b0;
			cmd_pos       <= 7'h00;
			frame_discard <= 1'b0;
			resp_block    <= 1'b0;
		end else begin
			state         <= next_state;
			status        <= next_status;
			frame_bad     <= next_bad;
			frame_discard <= next_discard;
			if (frame_start) begin
				cmd_pos <= 7'h00;
			end else if (cmd_valid && state == S_BODY) begin
				cmd_pos <= cmd_pos + 7'h01;
			end
			// held from the moment of overflow until the next frame starts or a restart
			if (frame_start) begin
				resp_block <= 1'b0;
			end else if (oversize) begin
				resp_block <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// software registers and interrupt
	// ****************************************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			check_en   <= 1'b0;
			mgmt_reset <= 1'b0;
			own_addr   <= `OWN_ADDR_RESET;
			int_status <= {`EV_WIDTH{1'b0}};
			int_mask   <= {`EV_WIDTH{1'b0}};
			irq        <= 1'b0;
		end else begin
			int_status <= next_int;
			irq        <= |(next_int & int_mask);
			// the restart request lasts exactly one cycle
			mgmt_reset <= wr_req && hit(wb_adr_i, `OFF_CTRL) && wb_sel_i[3] &&
				wb_dat_i[`CTRL_RESET_BIT];
			if (wr_req && hit(wb_adr_i, `OFF_CTRL) && wb_sel_i[3]) begin
				check_en <= wb_dat_i[`CTRL_CHECK_BIT];
			end
			if (wr_req && hit(wb_adr_i, `OFF_INT_MASK) && wb_sel_i[0]) begin
				int_mask <= wb_dat_i[`EV_WIDTH-1:0];
			end
			if (wr_req && hit(wb_adr_i, `OFF_OWN_HI)) begin
				own_addr[47:32] <= own_hi_wr[15:0];
			end
			if (wr_req && hit(wb_adr_i, `OFF_OWN_LO)) begin
				own_addr[31:0] <= merge(own_addr[31:0], wb_dat_i, wb_sel_i);
			end
		end
	end

	// ****************************************************************
	// bus answer, one wait cycle, unmapped reads return zero
	// ****************************************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				// reads only sample; no flag is disturbed
				if (hit(wb_adr_i, `OFF_STATUS)) begin
					wb_dat_o <= status;
				end else if (hit(wb_adr_i, `OFF_CTRL)) begin
					wb_dat_o <= ctrl_rd;
				end else if (hit(wb_adr_i, `OFF_INT_STATUS)) begin
					wb_dat_o <= {28'h000_0000, int_status};
				end else if (hit(wb_adr_i, `OFF_INT_MASK)) begin
					wb_dat_o <= {28'h000_0000, int_mask};
				end else if (hit(wb_adr_i, `OFF_OWN_HI)) begin
					wb_dat_o <= {16'h0000, own_addr[47:32]};
				end else if (hit(wb_adr_i, `OFF_OWN_LO)) begin
					wb_dat_o <= own_addr[31:0];
				end
			end
		end
	end

endmodule

// file: rtl/inband_mgmt_defs.vh
// constants for the in-band management status block
`ifndef INBAND_MGMT_DEFS_VH
`define INBAND_MGMT_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFF_CTRL        16'h0104
`define OFF_STATUS      16'h0110
`define OFF_INT_STATUS  16'h0140
`define OFF_INT_MASK    16'h0144
`define OFF_OWN_HI      16'h0148
`define OFF_OWN_LO      16'h014c

// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_CHECK_BIT  30
`define CTRL_RESET_BIT  29

// ****************************************************************
// operation status fields
// ****************************************************************
`define ST_GOOD_BIT     31
`define ST_RESP_BIT     30
`define ST_EXEC_BIT     29
`define ST_MAC_BIT      14
`define ST_FMT_BIT      13
`define ST_CODE_BIT     12
`define ST_CMD_BIT      11
`define ST_SIZE_BIT     10
`define ST_LOC_MSB      6
`define ST_LOC_LSB      0
`define ST_RSVD_HI_MSB  28
`define ST_RSVD_HI_LSB  15
`define ST_RSVD_LO_MSB  9
`define ST_RSVD_LO_LSB  7
`define ST_RESET        32'h0000_0000

// ****************************************************************
// interrupt event bits
// ****************************************************************
`define EV_GOOD         0
`define EV_RESP         1
`define EV_EXEC         2
`define EV_ERR          3
`define EV_WIDTH        4

// ****************************************************************
// frame content
// ****************************************************************
`define ACCESS_FORMAT   16'h9800
`define ACCESS_CODE_A   16'h0001
`define ACCESS_CODE_B   16'h0002
`define CMD_CODE_0      8'h01
`define CMD_CODE_1      8'h02
`define CMD_CODE_2      8'h03
`define CMD_CODE_3      8'h04
`define MAX_FRAME_BYTES 9'h140
`define OWN_ADDR_RESET  48'h0010_a1ff_ffff

`endif

// file: rtl/frame_len.v
// byte counter flagging management frames above the size limit
`timescale 1ns/1ps
`include "inband_mgmt_defs.vh"

module frame_len (
	input  wire clk,
	input  wire nrst,
	input  wire clr,
	input  wire byte_valid,
	output wire oversize
);

	reg [8:0] count;

	// saturates one past the limit so a long frame never wraps to small
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= 9'h000;
		end else if (clr) begin
			count <= 9'h000;
		end else if (byte_valid && count <= `MAX_FRAME_BYTES) begin
			count <= count + 9'h001;
		end
	end

	assign oversize = (count > `MAX_FRAME_BYTES);

endmodule

// file: rtl/hdr_check.v
// header field checks for a received management frame
`timescale 1ns/1ps
`include "inband_mgmt_defs.vh"

module hdr_check (
	input  wire        check_en,
	input  wire [47:0] dest_addr,
	input  wire [47:0] own_addr,
	input  wire [15:0] access_format,
	input  wire [15:0] access_code,
	output wire        mac_err,
	output wire        fmt_err,
	output wire        code_err
);

	assign mac_err  = check_en && (dest_addr != own_addr);
	assign fmt_err  = (access_format != `ACCESS_FORMAT);
	assign code_err = (access_code != `ACCESS_CODE_A) &&
		(access_code != `ACCESS_CODE_B);

endmodule

// file: sim/status_monitor.sv
// assertion checker on the ports of the management status block
`timescale 1ns/1ps
module status_monitor (
	input wire        clk,
	input wire        nrst,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire        wb_ack_o,
	input wire        frame_start,
	input wire        byte_valid,
	input wire        hdr_valid,
	input wire        frame_discard,
	input wire        resp_block,
	input wire        mgmt_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// bus writes may clear the block flag through a restart
	sequence s_quiet;
		resp_block && !frame_start && !wb_stb_i && !mgmt_reset;
	endsequence
	ack_answer_a: assert property (s_take |=> wb_ack_o)
		else $error("request not answered in the next cycle");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside an answer");
	discard_cause_a: assert property (frame_discard |-> $past(hdr_valid))
		else $error("discard without a header");
	discard_once_a: assert property (frame_discard |=> !frame_discard)
		else $error("discard longer than one cycle");
	restart_cause_a: assert property (mgmt_reset |->
		$past(wb_stb_i && wb_we_i && wb_dat_i[29]))
		else $error("restart without a control write");
	restart_once_a: assert property (mgmt_reset |=> !mgmt_reset)
		else $error("restart not self clearing");
	block_cause_a: assert property ($rose(resp_block) |->
		$past(byte_valid) || $past(byte_valid, 2))
		else $error("response block without a byte");
	block_hold_a: assert property (s_quiet |=> resp_block)
		else $error("response block dropped inside a frame");
endmodule

// file: sim/mgmt_host.sv
// behavioural remote host producing management frame events
`timescale 1ns/1ps
module mgmt_host (
	input  wire        clk,
	output reg         fs,
	output reg         tm,
	output reg         bv,
	output reg         hv,
	output reg  [47:0] da,
	output reg  [15:0] af,
	output reg  [15:0] ac,
	output reg         cv,
	output reg  [7:0]  cc,
	output reg         fe,
	output reg         ed,
	output reg         rs
);
	initial begin
		{fs, tm, bv, hv, cv, fe, ed, rs} = 8'h00;
		{da, af, ac, cc} = 88'h0;
	end
	// released fields are inverted so stale values never pass for valid ones
	task automatic send(input logic tag, input int nb, input logic [47:0] d,
		input logic [15:0] f, input logic [15:0] c, input int ncmd, input int bad);
		int i;
		@(posedge clk);
		fs <= 1'b1;
		tm <= tag;
		for (i = 0; i < nb; i++) begin
			@(posedge clk);
			fs <= 1'b0;
			tm <= ~tag;
			bv <= 1'b1;
		end
		@(posedge clk);
		bv <= 1'b0;
		hv <= 1'b1;
		{da, af, ac} <= {d, f, c};
		@(posedge clk);
		hv <= 1'b0;
		{da, af, ac} <= ~{d, f, c};
		for (i = 0; i < ncmd; i++) begin
			cv <= 1'b1;
			cc <= (i == bad) ? 8'h99 : 8'(i % 4 + 1);
			@(posedge clk);
		end
		cv <= 1'b0;
		cc <= ~cc;
		fe <= 1'b1;
		@(posedge clk);
		fe <= 1'b0;
	endtask
	task automatic pulse(input logic resp);
		@(posedge clk);
		rs <= resp;
		ed <= ~resp;
		@(posedge clk);
		{rs, ed} <= 2'b00;
	endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the management status block
`timescale 1ns/1ps
`include "inband_mgmt_defs.vh"
module tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [15:0] adr = 16'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	wire  [31:0] rdat;
	wire         ack, fs, tm, bv, hv, cv, fe, ed, rs, disc, blk, mrst, irq;
	wire  [47:0] da;
	wire  [15:0] af, ac;
	wire  [7:0]  cc;
	int          errors = 0;
	int          checked = 0;
	int          ndisc = 0;
	int          xdisc = 0;
	int          nrs = 0;
	logic [31:0] seed = 32'h2089;
	logic [31:0] st = 32'h0;
	logic [3:0]  ist = 4'h0;
	logic [3:0]  msk = 4'h0;
	logic        chk_en = 1'b0;
	logic [31:0] q;
	logic [47:0] own = `OWN_ADDR_RESET;
	logic [15:0] codes [5] = '{16'h0001, 16'h0002, 16'h0003, 16'h0000, 16'hffff};

	inband_mgmt_status inband_mgmt_status_inst (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .frame_start(fs), .tag_match(tm), .byte_valid(bv),
		.hdr_valid(hv), .dest_addr(da), .access_format(af), .access_code(ac), .cmd_valid(cv),
		.cmd_code(cc), .frame_end(fe), .exec_done(ed), .resp_sent(rs), .frame_discard(disc),
		.resp_block(blk), .mgmt_reset(mrst), .irq(irq));
	mgmt_host mgmt_host_inst (.clk(clk), .fs(fs), .tm(tm), .bv(bv), .hv(hv), .da(da),
		.af(af), .ac(ac), .cv(cv), .cc(cc), .fe(fe), .ed(ed), .rs(rs));

	initial forever #5 clk = ~clk;
	always @(posedge clk) if (disc === 1'b1) ndisc++;
	always @(posedge clk) if (mrst === 1'b1) nrs++;

	// ********
	// helpers
	// ********
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50) begin
			check("ack", 1, 0);
			test_done;
		end
		{cyc, stb} <= 2'b00;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0);
		check(what, exp, q);
	endtask
	task automatic verify;
		rd(`OFF_STATUS, st, "status");
		rd(`OFF_INT_STATUS, {28'h0, ist}, "int status");
		check("irq", {31'h0, |(ist & msk)}, {31'h0, irq});
		check("discards", xdisc, ndisc);
	endtask
	// the model of the status word is updated from the frame contents and the address check setting
	task automatic frame(input logic tag, input int nb, input logic [47:0] d,
		input logic [15:0] f, input logic [15:0] c, input int ncmd, input int bad);
		logic [31:0] e;
		e = 32'h0;
		if (tag) st = st & 32'h8000_0000;
		e[10] = nb > 320;
		e[14] = chk_en && d !== own;
		e[13] = f !== `ACCESS_FORMAT;
		e[12] = c !== `ACCESS_CODE_A && c !== `ACCESS_CODE_B;
		if (bad >= 0 && !e[14]) {e[11], e[6:0]} = {1'b1, 7'(bad)};
		if (e[14]) xdisc++;
		mgmt_host_inst.send(tag, nb, d, f, c, e[14] ? 0 : ncmd, bad);
		if (e == 0) {st[31], ist[0]} = 2'b11;
		else ist[3] = 1'b1;
		st = st | e;
	endtask
	task test_done;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// ********
	// scenarios
	// ********
	initial begin
		#500_000;
		errors++;
		test_done;
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd(`OFF_STATUS, 32'h0, "status reset");
		rd(`OFF_CTRL, 32'h0, "ctrl reset");
		rd(`OFF_OWN_HI, 32'h0000_0010, "own hi");
		rd(`OFF_OWN_LO, 32'ha1ff_ffff, "own lo");
		bus(1'b1, 16'h0200, 32'hffff_ffff);
		rd(16'h0200, 32'h0, "unmapped");
		bus(1'b1, `OFF_INT_MASK, 32'h0);
		frame(1, 40 + rnd() % 281, own, `ACCESS_FORMAT, `ACCESS_CODE_A, 1 + rnd() % 4, -1);
		verify;
		verify;
		frame(1, 320, own, `ACCESS_FORMAT, `ACCESS_CODE_B, 2, -1);
		check("block at limit", 0, blk);
		frame(1, 321, own, `ACCESS_FORMAT, `ACCESS_CODE_B, 2, -1);
		check("block above limit", 1, blk);
		verify;
		mgmt_host_inst.pulse(1'b1);
		{st[30], ist[1]} = 2'b11;
		mgmt_host_inst.pulse(1'b0);
		{st[29], ist[2]} = 2'b11;
		verify;
		frame(0, 60, own, `ACCESS_FORMAT, `ACCESS_CODE_A, 2, -1);
		verify;
		frame(1, 60, own, `ACCESS_FORMAT, `ACCESS_CODE_A, 2, -1);
		verify;
		foreach (codes[i]) begin
			frame(1, 60, own, `ACCESS_FORMAT, codes[i], 2, -1);
			verify;
		end
		frame(1, 60, own, 16'h9801, `ACCESS_CODE_A, 2, -1);
		verify;
		frame(1, 80, own, `ACCESS_FORMAT, `ACCESS_CODE_B, 10, rnd() % 10);
		verify;
		bus(1'b1, `OFF_CTRL, 32'h4000_0000);
		chk_en = 1'b1;
		rd(`OFF_CTRL, 32'h4000_0000, "ctrl check");
		frame(1, 60, 48'h0, `ACCESS_FORMAT, `ACCESS_CODE_A, 2, -1);
		verify;
		frame(1, 60, own, `ACCESS_FORMAT, `ACCESS_CODE_A, 2, -1);
		verify;
		bus(1'b1, `OFF_CTRL, 32'h0);
		chk_en = 1'b0;
		frame(1, 60, 48'h0, `ACCESS_FORMAT, `ACCESS_CODE_A, 2, -1);
		verify;
		bus(1'b1, `OFF_INT_MASK, 32'hf);
		msk = 4'hf;
		verify;
		bus(1'b1, `OFF_INT_STATUS, {28'h0, ist});
		ist = 4'h0;
		bus(1'b1, `OFF_INT_MASK, 32'h0);
		msk = 4'h0;
		frame(1, 330, own, `ACCESS_FORMAT, `ACCESS_CODE_A, 2, -1);
		verify;
		bus(1'b1, `OFF_CTRL, 32'h2000_0000);
		st = 32'h0;
		verify;
		check("block after restart", 0, blk);
		check("restarts", 1, nrs);
		rd(`OFF_CTRL, 32'h0, "ctrl restart");
		test_done;
	end
endmodule

bind inband_mgmt_status status_monitor status_monitor_inst (.clk(clk), .nrst(nrst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_start(frame_start),
	.byte_valid(byte_valid), .hdr_valid(hdr_valid), .frame_discard(frame_discard),
	.resp_block(resp_block), .mgmt_reset(mgmt_reset));
